// [design/osb_sideband.sv]
// Sideband control and status for pluggable optical module ports and front pins.
// Assumes user logic on clk; all module and pin inputs are asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Signal loss input is asynchronous, module driven.
// - Transmit off high disables module transmitter.
// - Transmit fault input is asynchronous, module driven.
// - Supply good shows supply enabled, socket rate.
// - Supply good may drop under over-power.
// - Module missing input high when nothing fitted.
// - Socket rate runs continuously from divider.
module osb_sideband #(
    parameter int unsigned NUM_PORTS = osb_pkg::NUM_PORTS_DEF,  // Optical ports.
    parameter int unsigned NUM_PINS  = osb_pkg::NUM_PINS_DEF    // Front-panel pins.
) (
    input  wire logic                                    clk,
    input  wire logic                                    resetn,
    // User side, same clock.
    input  wire logic [NUM_PORTS-1:0][osb_pkg::RATE_W-1:0] rxRateMbps,
    input  wire logic [NUM_PORTS-1:0][osb_pkg::RATE_W-1:0] txRateMbps,
    input  wire logic [NUM_PORTS-1:0]                    txOffReq,
    input  wire logic [NUM_PORTS-1:0]                    supplyReq,
    input  wire logic [NUM_PORTS-1:0]                    overPowerClr,
    input  wire logic [NUM_PORTS-1:0]                    mgmtClkPullLow,
    input  wire logic [NUM_PORTS-1:0]                    mgmtDataPullLow,
    input  wire logic [NUM_PINS-1:0]                     pinOutData,
    input  wire logic [NUM_PINS-1:0]                     pinDriveReq,
    output var  osb_pkg::osb_mod_stat_t [NUM_PORTS-1:0]  modStat,
    output var  logic [NUM_PINS-1:0]                     pinInData,
    // Module side, asynchronous.
    input  wire osb_pkg::osb_mod_in_t [NUM_PORTS-1:0]    modIn,
    input  wire logic [NUM_PORTS-1:0]                    opticalSupplyOk,
    output var  osb_pkg::osb_mod_out_t [NUM_PORTS-1:0]   modOut,
    output var  logic [NUM_PORTS-1:0]                    opticalSupplyOn,
    // Front-panel pins, asynchronous.
    input  wire logic [NUM_PINS-1:0]                     frontPinIn,
    output var  logic [NUM_PINS-1:0]                     frontPinOut,
    output var  logic [NUM_PINS-1:0]                     frontPinDriveN
);

    // Compares a line rate in Mbps against the 4.25 Gbps threshold.
    function automatic logic rateAbove(input logic [osb_pkg::RATE_W-1:0] rate);
        rateAbove = (rate > osb_pkg::RATE_THRESH_MBPS);
    endfunction

    // Socket tick divider state.
    logic [osb_pkg::DIV_W-1:0] divCnt_ff;   // Counts system cycles per tick.
    logic [osb_pkg::DIV_W-1:0] nxt_divCnt;  // Next divider count.
    logic                      socketTick;  // One-cycle pulse at 40 MHz.

    // The divider wraps at its last count and flags the tick on that cycle.
    assign socketTick = (divCnt_ff == osb_pkg::DIV_LAST);
    assign nxt_divCnt = socketTick ? '0 : divCnt_ff + 1'b1;

    // Free-running socket divider, independent of any module being present.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            divCnt_ff <= '0;
        end
        else
        begin
            divCnt_ff <= nxt_divCnt;
        end
    end

    // Synchroniser stages for the module inputs, supply good and front pins.
    osb_pkg::osb_mod_in_t [NUM_PORTS-1:0] modMeta_ff;   // First stage, read by second only.
    osb_pkg::osb_mod_in_t [NUM_PORTS-1:0] modSync_ff;   // Second stage, safe to use.
    logic [NUM_PORTS-1:0]                 okMeta_ff;    // First stage of supply good.
    logic [NUM_PORTS-1:0]                 okSync_ff;    // Second stage of supply good.
    logic [NUM_PINS-1:0]                  pinMeta_ff;   // First stage of front pins.
    logic [NUM_PINS-1:0]                  pinSync_ff;   // Second stage of front pins.

    // Two-flop synchronisers for every asynchronous input.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            modMeta_ff <= '0;
            modSync_ff <= '0;
            okMeta_ff  <= '0;
            okSync_ff  <= '0;
            pinMeta_ff <= '0;
            pinSync_ff <= '0;
        end
        else
        begin
            modMeta_ff <= modIn;
            modSync_ff <= modMeta_ff;
            okMeta_ff  <= opticalSupplyOk;
            okSync_ff  <= okMeta_ff;
            pinMeta_ff <= frontPinIn;
            pinSync_ff <= pinMeta_ff;
        end
    end

    // Per-port control and status.
    genvar p;
    generate
        for (p = 0; p < NUM_PORTS; p++)
        begin : gPort
            logic supplyOn_ff;     // Supply enable, changes only on socket ticks.
            logic supplyOk_ff;     // Supply good sampled on socket ticks.
            logic overPower_ff;    // Sticky over-power flag.
            logic nxt_supplyOn;    // Next supply enable.
            logic nxt_supplyOk;    // Next sampled supply good.
            logic nxt_overPower;   // Next over-power flag.
            logic okFell;          // Supply good dropped while enabled.
            osb_pkg::osb_mod_out_t outReg_ff;   // Registered module drive.
            osb_pkg::osb_mod_out_t nxt_out;     // Next module drive.
            osb_pkg::osb_mod_stat_t statReg_ff; // Registered user status.
            osb_pkg::osb_mod_stat_t nxt_stat;   // Next user status.

            // Supply enable and supply good move only in the socket rate.
            assign nxt_supplyOn = socketTick ? supplyReq[p] : supplyOn_ff;
            assign nxt_supplyOk = socketTick ? okSync_ff[p] : supplyOk_ff;

            // An over-power shows as supply good falling while still enabled.
            assign okFell = socketTick & supplyOn_ff & supplyOk_ff & ~okSync_ff[p];

            // A new drop beats a clear arriving in the same cycle.
            assign nxt_overPower = okFell | (overPower_ff & ~overPowerClr[p]);

            // Module drive; the wires are pulled low only once the supply is on.
            assign nxt_out.rxRateSelect = rateAbove(rxRateMbps[p]);
            assign nxt_out.txRateSelect = rateAbove(txRateMbps[p]);
            assign nxt_out.txOff        = txOffReq[p];
            assign nxt_out.mgmtClkOut   = 1'b0;
            assign nxt_out.mgmtClkOe    = mgmtClkPullLow[p] & supplyOn_ff;
            assign nxt_out.mgmtDataOut  = 1'b0;
            assign nxt_out.mgmtDataOe   = mgmtDataPullLow[p] & supplyOn_ff;

            // Status toward user logic, built from synchronised values only.
            assign nxt_stat.rxSignalLoss  = modSync_ff[p].rxSignalLoss;
            assign nxt_stat.txFault       = modSync_ff[p].txFault;
            assign nxt_stat.moduleMissing = modSync_ff[p].moduleMissing;
            assign nxt_stat.mgmtClk       = modSync_ff[p].mgmtClkIn;
            assign nxt_stat.mgmtData      = modSync_ff[p].mgmtDataIn;
            assign nxt_stat.supplyOn      = nxt_supplyOn;
            assign nxt_stat.supplyOk      = nxt_supplyOk;
            assign nxt_stat.overPower     = nxt_overPower;

            // Port registers; reset leaves the transmitter off and supply down.
            always_ff @(posedge clk or negedge resetn)
            begin
                if (!resetn)
                begin
                    supplyOn_ff        <= osb_pkg::RST_SUPPLY_ON;
                    supplyOk_ff        <= osb_pkg::RST_LOW;
                    overPower_ff       <= osb_pkg::RST_LOW;
                    outReg_ff          <= '0;
                    outReg_ff.txOff    <= osb_pkg::RST_TX_OFF;
                    statReg_ff         <= '0;
                end
                else
                begin
                    supplyOn_ff  <= nxt_supplyOn;
                    supplyOk_ff  <= nxt_supplyOk;
                    overPower_ff <= nxt_overPower;
                    outReg_ff    <= nxt_out;
                    statReg_ff   <= nxt_stat;
                end
            end

            // Outputs come straight from the port registers.
            assign modOut[p]          = outReg_ff;
            assign modStat[p]         = statReg_ff;
            assign opticalSupplyOn[p] = supplyOn_ff;
        end
    endgenerate

    // Front pin registers.
    logic [NUM_PINS-1:0] pinOut_ff;    // Output data toward the pins.
    logic [NUM_PINS-1:0] pinDrvN_ff;   // Active-low driver enable.
    logic [NUM_PINS-1:0] pinIn_ff;     // Synchronised pin levels to the user.

    // Front pins: the driver is enabled by driving the enable low.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pinOut_ff  <= '0;
            pinDrvN_ff <= {NUM_PINS{osb_pkg::RST_PIN_DRV_N}};
            pinIn_ff   <= '0;
        end
        else
        begin
            pinOut_ff  <= pinOutData;
            pinDrvN_ff <= ~pinDriveReq;
            pinIn_ff   <= pinSync_ff;
        end
    end

    // Pin outputs come straight from their registers.
    assign frontPinOut    = pinOut_ff;
    assign frontPinDriveN = pinDrvN_ff;
    assign pinInData      = pinIn_ff;

endmodule

`default_nettype wire

// [design/osb_pkg.sv]
// Shared constants and carrier types for the optical module port sideband block.
// Assumes a single 200 MHz system clock; the 40 MHz socket rate is an enable pulse.
package osb_pkg;

    // System clock rate in MHz.
    localparam int unsigned CLK_FREQ_MHZ    = 200;
    // Socket rate in MHz, at which supply enable and supply good are handled.
    localparam int unsigned SOCKET_FREQ_MHZ = 40;
    // Cycles of the system clock per socket tick.
    localparam int unsigned SOCKET_DIV      = CLK_FREQ_MHZ / SOCKET_FREQ_MHZ;
    // Width of the socket tick divider.
    localparam int unsigned DIV_W           = 3;
    // Last count of the socket tick divider.
    localparam logic [DIV_W-1:0] DIV_LAST   = DIV_W'(SOCKET_DIV - 1);

    // Width of the line rate fields given by the user, in Mbps.
    localparam int unsigned RATE_W          = 16;
    // Line rate threshold of 4.25 Gbps expressed in Mbps.
    localparam logic [RATE_W-1:0] RATE_THRESH_MBPS = 16'h109A;

    // Documented number of optical ports and front-panel pins.
    localparam int unsigned NUM_PORTS_DEF   = 4;
    localparam int unsigned NUM_PINS_DEF    = 4;

    // Values after reset.
    localparam logic RST_TX_OFF    = 1'b1;   // Transmitter held off.
    localparam logic RST_SUPPLY_ON = 1'b0;   // Optical supply off.
    localparam logic RST_PIN_DRV_N = 1'b1;   // Front pin driver released.
    localparam logic RST_LOW       = 1'b0;   // Generic low reset value.

    // Raw module inputs as they arrive on the pins of one port.
    typedef struct packed {
        logic rxSignalLoss;   // Module sees no incoming optical signal.
        logic txFault;        // Module laser is operating incorrectly.
        logic moduleMissing;  // High when no module is fitted.
        logic mgmtClkIn;      // Level on the management clock wire.
        logic mgmtDataIn;     // Level on the management data wire.
    } osb_mod_in_t;

    // Drive toward the module of one port.
    typedef struct packed {
        logic rxRateSelect;   // High for receive rates above 4.25 Gbps.
        logic txRateSelect;   // High for transmit rates above 4.25 Gbps.
        logic txOff;          // High disables the transmitter.
        logic mgmtClkOut;     // Always low: open drain.
        logic mgmtClkOe;      // High while pulling the clock wire low.
        logic mgmtDataOut;    // Always low: open drain.
        logic mgmtDataOe;     // High while pulling the data wire low.
    } osb_mod_out_t;

    // Synchronised status of one port toward user logic.
    typedef struct packed {
        logic rxSignalLoss;   // Synchronised signal loss.
        logic txFault;        // Synchronised transmit fault.
        logic moduleMissing;  // Synchronised module missing.
        logic mgmtClk;        // Synchronised management clock level.
        logic mgmtData;       // Synchronised management data level.
        logic supplyOn;       // Supply enable as currently driven.
        logic supplyOk;       // Supply good as sampled on a socket tick.
        logic overPower;      // Sticky: supply good dropped while enabled.
    } osb_mod_stat_t;

endpackage

// [tb/osb_sideband_assertions.sv]
// Concurrent checks on the ports of the optical module sideband block.
// Assumes binding to osb_sideband; port 0 and the front pins are watched.
`timescale 1ns/1ps
`default_nettype none
module osb_sideband_sva #(
    parameter int unsigned NUM_PORTS = 4,  // Optical ports.
    parameter int unsigned NUM_PINS  = 4   // Front-panel pins.
) (
    input wire logic                                      clk,
    input wire logic                                      resetn,
    input wire logic [NUM_PORTS-1:0][osb_pkg::RATE_W-1:0] rxRateMbps,
    input wire logic [NUM_PORTS-1:0][osb_pkg::RATE_W-1:0] txRateMbps,
    input wire logic [NUM_PORTS-1:0]                      txOffReq,
    input wire logic [NUM_PORTS-1:0]                      supplyReq,
    input wire logic [NUM_PORTS-1:0]                      overPowerClr,
    input wire logic [NUM_PORTS-1:0]                      mgmtDataPullLow,
    input wire logic [NUM_PINS-1:0]                       pinOutData,
    input wire logic [NUM_PINS-1:0]                       pinDriveReq,
    input wire osb_pkg::osb_mod_stat_t [NUM_PORTS-1:0]    modStat,
    input wire osb_pkg::osb_mod_in_t [NUM_PORTS-1:0]      modIn,
    input wire logic [NUM_PORTS-1:0]                      opticalSupplyOk,
    input wire osb_pkg::osb_mod_out_t [NUM_PORTS-1:0]     modOut,
    input wire logic [NUM_PORTS-1:0]                      opticalSupplyOn,
    input wire logic [NUM_PINS-1:0]                       frontPinOut,
    input wire logic [NUM_PINS-1:0]                       frontPinDriveN
);
    // Status bits of port 0 at the pins and as reported.
    wire logic [2:0] stIn  = {modIn[0].rxSignalLoss, modIn[0].txFault, modIn[0].moduleMissing};
    wire logic [2:0] stOut = {modStat[0].rxSignalLoss, modStat[0].txFault, modStat[0].moduleMissing};
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!resetn);
    // Supply on with good supply, then good supply lost while still enabled.
    sequence s_ok_on;
        (opticalSupplyOn[0] && opticalSupplyOk[0])[*8];
    endsequence
    sequence s_ok_lost;
        (opticalSupplyOn[0] && !opticalSupplyOk[0] && !overPowerClr[0])[*8];
    endsequence
    property p_rx_rate;
        $past(resetn) |-> modOut[0].rxRateSelect == ($past(rxRateMbps[0]) > 16'h109A);
    endproperty
    property p_tx_rate;
        $past(resetn) |-> modOut[0].txRateSelect == ($past(txRateMbps[0]) > 16'h109A);
    endproperty
    property p_tx_off;
        $past(resetn) |-> modOut[0].txOff == $past(txOffReq[0]);
    endproperty
    property p_open_drain;
        modOut[0].mgmtClkOut == 1'b0 && modOut[0].mgmtDataOut == 1'b0;
    endproperty
    property p_mgmt_gate;
        $past(resetn) |-> modOut[0].mgmtDataOe == ($past(mgmtDataPullLow[0]) && $past(opticalSupplyOn[0]));
    endproperty
    property p_front_pin;
        $past(resetn) |-> frontPinDriveN == ~$past(pinDriveReq) && frontPinOut == $past(pinOutData);
    endproperty
    property p_supply_tick;
        $changed(opticalSupplyOn[0]) |=> $stable(opticalSupplyOn[0])[*4];
    endproperty
    property p_supply_follow;
        supplyReq[0][*7] |-> opticalSupplyOn[0];
    endproperty
    // The reset guard keeps the three flop stages after a release out of the check.
    property p_sync;
        ($stable(stIn) && $past(resetn, 3))[*4] |-> stOut == stIn;
    endproperty
    property p_over_power;
        s_ok_on ##1 s_ok_lost |=> ##[0:2] modStat[0].overPower;
    endproperty
    a_rx_rate: assert property (p_rx_rate) else $error("rx rate select wrong");
    a_tx_rate: assert property (p_tx_rate) else $error("tx rate select wrong");
    a_tx_off: assert property (p_tx_off) else $error("tx off wrong");
    a_open_drain: assert property (p_open_drain) else $error("wire driven high");
    a_mgmt_gate: assert property (p_mgmt_gate) else $error("wire pull wrong");
    a_front_pin: assert property (p_front_pin) else $error("front pin wrong");
    a_supply_tick: assert property (p_supply_tick) else $error("supply off tick");
    a_supply_follow: assert property (p_supply_follow) else $error("supply late");
    a_sync: assert property (p_sync) else $error("status wrong");
    a_over_power: assert property (p_over_power) else $error("over-power missed");
endmodule
bind osb_sideband osb_sideband_sva #(.NUM_PORTS(NUM_PORTS), .NUM_PINS(NUM_PINS)) u_sva (
    .clk, .resetn, .rxRateMbps, .txRateMbps, .txOffReq, .supplyReq, .overPowerClr,
    .mgmtDataPullLow, .pinOutData, .pinDriveReq, .modStat, .modIn, .opticalSupplyOk,
    .modOut, .opticalSupplyOn, .frontPinOut, .frontPinDriveN);
`default_nettype wire

// [tb/osb_module_model.sv]
// Behavioural model of the modules and front pins beside the sideband block.
// Assumes the bench commands faults; wires have pull-ups to the high level.
`timescale 1ns/1ps
`default_nettype none
module osb_module_model #(
    parameter int unsigned NP = 4,  // Ports.
    parameter int unsigned NF = 4   // Front pins.
) (
    input  wire logic [NP-1:0]                  supplyOn,   // Supply enable from the block.
    input  wire osb_pkg::osb_mod_out_t [NP-1:0] modOut,     // Drive from the block.
    input  wire logic [NP-1:0]                  lossCmd,    // Commanded signal loss.
    input  wire logic [NP-1:0]                  faultCmd,   // Commanded laser fault.
    input  wire logic [NP-1:0]                  missCmd,    // Commanded empty socket.
    input  wire logic [NP-1:0]                  overCmd,    // Commanded over-power trip.
    input  wire logic [NF-1:0]                  pinOut,     // Block pin data.
    input  wire logic [NF-1:0]                  pinDriveN,  // Block pin driver, low drives.
    input  wire logic [NF-1:0]                  pinExt,     // External source level.
    output wire osb_pkg::osb_mod_in_t [NP-1:0]  modIn,      // Module lines toward the block.
    output wire logic [NP-1:0]                  supplyOk,   // Supply good.
    output wire logic [NF-1:0]                  pinIn       // Pin level.
);
    // Supply good follows enable and drops on an over-power trip.
    assign supplyOk = supplyOn & ~overCmd;
    // A pin shows the block's data while driven, else the external source.
    assign pinIn = (pinOut & ~pinDriveN) | (pinExt & pinDriveN);
    for (genvar i = 0; i < NP; i++)
    begin : g_port
        assign modIn[i].rxSignalLoss  = lossCmd[i];
        assign modIn[i].txFault       = faultCmd[i];
        assign modIn[i].moduleMissing = missCmd[i];
        // Pull-ups hold the wires high unless the block pulls them low.
        assign modIn[i].mgmtClkIn  = ~modOut[i].mgmtClkOe;
        assign modIn[i].mgmtDataIn = ~modOut[i].mgmtDataOe;
    end
endmodule
`default_nettype wire

// [tb/test_optical_module_port_sideband.sv]
// Self-checking bench for the optical module sideband block.
// Assumes the package, design, checker and module model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_optical_module_port_sideband;
    logic [3:0][15:0] rxRate = '0, txRate = '0;                 // Requested line rates.
    logic [3:0] txOffReq = '0, supplyReq = '0, clr = '0, clkPull = '0, dataPull = '0;
    logic [3:0] lossCmd = '0, faultCmd = '0, missCmd = '0, overCmd = '0;  // Model commands.
    logic [3:0] pinData = '0, pinDrive = '0, pinExt = '0;       // Front pin stimulus.
    logic clk = 1'b0, resetn = 1'b0;                            // Clock and reset.
    osb_pkg::osb_mod_stat_t [3:0] modStat;                      // Reported status.
    osb_pkg::osb_mod_in_t [3:0]   modIn;                        // Module lines in.
    osb_pkg::osb_mod_out_t [3:0]  modOut;                       // Module lines out.
    wire logic [3:0] pinInData, pinIn, pinOut, pinDriveN, supplyOk, supplyOn;
    int errors = 0, nTests = 0, cycles = 0;                     // Counters.
    logic [15:0] rates [5] = '{16'h1099, 16'h109A, 16'h109B, 16'h0000, 16'hFFFF};
    osb_sideband dut (.clk, .resetn, .rxRateMbps(rxRate), .txRateMbps(txRate), .txOffReq,
        .supplyReq, .overPowerClr(clr), .mgmtClkPullLow(clkPull), .mgmtDataPullLow(dataPull),
        .pinOutData(pinData), .pinDriveReq(pinDrive), .modStat, .pinInData, .modIn,
        .opticalSupplyOk(supplyOk), .modOut, .opticalSupplyOn(supplyOn), .frontPinIn(pinIn),
        .frontPinOut(pinOut), .frontPinDriveN(pinDriveN));
    osb_module_model model (.supplyOn, .modOut, .lossCmd, .faultCmd, .missCmd, .overCmd,
        .pinOut, .pinDriveN, .pinExt, .modIn, .supplyOk, .pinIn);
    // Free-running 200 MHz clock.
    initial
    begin
        forever #2.5 clk = ~clk;
    end
    // Waits n edges, then lets their updates land.
    task automatic look(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Compares one value and reports a mismatch.
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        nTests++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Prints counts and the verdict, then stops.
    task automatic summarize;
        $display("errors %0d checks %0d", errors, nTests);
        if (errors == 0 && nTests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Cuts a hang short well past the expected run length.
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            errors++;
            summarize();
        end
    end
    initial
    begin
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        // Rates either side of the threshold, each port in turn.
        for (int i = 0; i < 5; i++)
        begin
            @(posedge clk);
            rxRate[i % 4] <= rates[i];
            txRate[i % 4] <= rates[(i + 1) % 5];
            look(2);
            chk("rxSel", modOut[i % 4].rxRateSelect, rates[i] > 16'h109A);
            chk("txSel", modOut[i % 4].txRateSelect, rates[(i + 1) % 5] > 16'h109A);
            chk("txOff", modOut[1].txOff, i[0]);
            @(posedge clk);
            txOffReq[1] <= ~i[0];
        end
        // Front pins: two driven, two left to the external source.
        @(posedge clk);
        pinData <= 4'hA;
        pinDrive <= 4'h3;
        pinExt <= 4'h5;
        clkPull <= 4'h1;
        dataPull <= 4'h1;
        look(5);
        chk("pinDriveN", pinDriveN, 4'hC);
        chk("pinInData", pinInData, 4'h6);
        chk("clkOe", modOut[0].mgmtClkOe, 1'b0);
        chk("mgmtClk", {modStat[0].mgmtClk, modStat[0].mgmtData}, 2'b11);
        // Supply on enables the wire pulls.
        @(posedge clk);
        supplyReq <= 4'h1;
        look(9);
        chk("supplyOn", {supplyOn, modStat[0].supplyOn}, 5'h03);
        chk("dataOe", modOut[0].mgmtDataOe, 1'b1);
        look(5);
        chk("mgmtClk", {modStat[0].mgmtClk, modStat[0].mgmtData}, 2'b00);
        chk("supplyOk", modStat[0].supplyOk, 1'b1);
        // Status inputs on different ports.
        @(posedge clk);
        lossCmd <= 4'h5;
        faultCmd <= 4'h3;
        missCmd <= 4'h9;
        overCmd <= 4'h1;
        look(4);
        chk("loss", {modStat[2].rxSignalLoss, modStat[1].rxSignalLoss,
            modStat[0].rxSignalLoss}, 3'b101);
        chk("fault", {modStat[2].txFault, modStat[1].txFault, modStat[0].txFault}, 3'b011);
        chk("missing", {modStat[3].moduleMissing, modStat[2].moduleMissing,
            modStat[0].moduleMissing}, 3'b101);
        look(10);
        chk("overPower", {modStat[0].overPower, modStat[0].supplyOk}, 2'b10);
        @(posedge clk);
        overCmd <= 4'h0;
        clr <= 4'h1;
        @(posedge clk);
        clr <= 4'h0;
        look(2);
        chk("overClr", modStat[0].overPower, 1'b0);
        // Reset in mid-run returns every output to its rest value.
        @(posedge clk);
        resetn <= 1'b0;
        look(2);
        chk("rstTx", {modOut[0].txOff, modOut[0].rxRateSelect, supplyOn}, 6'h20);
        chk("rstPin", pinDriveN, 4'hF);
        @(posedge clk);
        resetn <= 1'b1;
        look(8);
        chk("supplyBack", supplyOn, 4'h1);
        summarize();
    end
endmodule
`default_nettype wire
